// *** src/tpm_pkg.sv ***
// Shared constants for the three-phase PWM modulator
package tpm_pkg;
	// Scaling of the sample codes
	localparam int          ADC_W       = 12;
	localparam logic [11:0] ADC_FULL    = 12'hfff;
	localparam logic [11:0] ADC_MID     = 12'h800;
	localparam int          BUS_FULL_MV = 111000;
	localparam int          OV_MV       = 28000;
	localparam int          UV_MV       = 12000;
	localparam logic [11:0] OV_CODE     = 12'(OV_MV * 4095 / BUS_FULL_MV);
	localparam logic [11:0] UV_CODE     = 12'(UV_MV * 4095 / BUS_FULL_MV);
	// Timing
	localparam int CLK_MHZ       = 50;
	localparam int OFFSET_CAL_US = 1000;
	localparam int OPEN_LOOP_US  = 2000;
	localparam int POS_LIMIT_US  = 500;
	localparam int CAR_DIV       = 2;
	// Register offsets (byte addresses)
	localparam logic [7:0] REG_CMD   = 8'h00;
	localparam logic [7:0] REG_CFG   = 8'h04;
	localparam logic [7:0] REG_REFU  = 8'h08;
	localparam logic [7:0] REG_REFV  = 8'h0c;
	localparam logic [7:0] REG_REFW  = 8'h10;
	localparam logic [7:0] REG_VCMD  = 8'h14;
	localparam logic [7:0] REG_DAC   = 8'h18;
	localparam logic [7:0] REG_STATE = 8'h1c;
	localparam logic [7:0] REG_BUS   = 8'h20;
	localparam logic [7:0] REG_MODF  = 8'h24;
	localparam logic [7:0] REG_ISTAT = 8'h28;
	localparam logic [7:0] REG_IMASK = 8'h2c;
	// Field positions
	localparam int CMD_DRIVE = 0;
	localparam int CMD_STOP  = 1;
	localparam int CMD_RESET = 2;
	localparam int CFG_SHUNT = 2;
	localparam int IS_OV     = 0;
	localparam int IS_UV     = 1;
	localparam int IS_OC     = 2;
	localparam int IS_POS    = 3;
	localparam int IS_W      = 4;
	// Reset values
	localparam logic [1:0]  CFG_MOD_RST = 2'h1;
	localparam logic [11:0] DAC_RST     = 12'hfff;
	// Modulation schemes
	localparam logic [1:0] carrier_compare_scheme = 2'h0;
	localparam logic [1:0] third_harmonic_scheme  = 2'h1;
	localparam logic [1:0] two_phase_scheme       = 2'h2;
	typedef enum logic [2:0] {
		SYS_STOPPED = 3'b001,
		SYS_DRIVING = 3'b010,
		SYS_ABNORMAL = 3'b100
	} tpm_sys_t;
	typedef enum logic [7:0] {
		offset_cal_running      = 8'b0000_0001,
		offset_cal_done         = 8'b0000_0010,
		position_detect_running = 8'b0000_0100,
		position_detect_done    = 8'b0000_1000,
		open_loop_start         = 8'b0001_0000,
		closed_loop_drive       = 8'b0010_0000,
		drive_brake             = 8'b0100_0000,
		drive_end               = 8'b1000_0000
	} tpm_run_t;
endpackage

// *** src/tpm_modulator.sv ***
// Three-phase PWM modulator with bus monitor, current protection and drive sequencer
// Function
// - Bus voltage codes 0 to fff map linearly onto 0 V to 111 V.
// - Bus voltage feeds the modulation factor and over/undervoltage checks.
// - Any bus voltage abnormality forces all PWM outputs inactive.
// - Single-shunt mode samples link current, -5 A to 5 A onto 0 to fff.
// - Three-shunt mode samples U, V, W currents, same scaling per channel.
// - Current compared with internal reference for overcurrent and position threshold.
// - Modulation factor is commanded voltage divided by bus voltage.
// - A phase switch is on while its command exceeds the triangle carrier.
// - Third harmonic offset is half of max plus min, subtracted from each phase.
// - Two-phase offset is max minus half bus voltage, subtracted from each phase.
// - Scheme select 0 carrier, 1 third harmonic (default), 2 two-phase.
// - System state is one of stopped, driving, abnormal.
// - Run state changes only on events or on a finished step.
// - Host raises stop, drive, reset; the block raises error on faults.
// - Driving steps offset cal, done, position detect, done, open loop, closed loop, stop.
// - Bus voltage above 28 V flags overvoltage and disables all six outputs.
// - Bus voltage below 12 V flags undervoltage and disables all six outputs.
//
// The address map and the strobed register port were decided locally.
`timescale 1ns/100ps
`default_nettype none
module tpm_modulator
	import tpm_pkg::*;
#(
	parameter int OFFSET_CAL_CYC = OFFSET_CAL_US * CLK_MHZ,
	parameter int OPEN_LOOP_CYC  = OPEN_LOOP_US * CLK_MHZ,
	parameter int POS_LIMIT_CYC  = POS_LIMIT_US * CLK_MHZ
) (
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic [7:0]  addr,
	input  wire logic [31:0] wdata,
	input  wire logic        wr,
	input  wire logic        rd,
	output logic      [31:0] rdata,
	input  wire logic [11:0] bus_voltage_channel,
	input  wire logic        bus_valid,
	input  wire logic [11:0] shunt_current_channel,
	input  wire logic [11:0] u_current_channel,
	input  wire logic [11:0] v_current_channel,
	input  wire logic [11:0] w_current_channel,
	input  wire logic        current_valid,
	input  wire logic        overcurrent_comparator,
	output logic      [5:0]  pwm_out,
	output logic             forced_output_shutoff,
	output logic             irq
);
	// Magnitude of a current code about mid scale
	function automatic logic [11:0] cur_mag(input logic [11:0] c);
		cur_mag = (c >= ADC_MID) ? (c - ADC_MID) : (ADC_MID - c);
	endfunction
	function automatic logic signed [13:0] max3(input logic signed [13:0] a, b, c);
		logic signed [13:0] m;
		m = (a > b) ? a : b;
		max3 = (m > c) ? m : c;
	endfunction
	function automatic logic signed [13:0] min3(input logic signed [13:0] a, b, c);
		logic signed [13:0] m;
		m = (a < b) ? a : b;
		min3 = (m < c) ? m : c;
	endfunction

	// Registers
	logic [1:0]  modulation_select;
	logic        three_shunt;
	logic [15:0] ref_u;
	logic [15:0] ref_v;
	logic [15:0] ref_w;
	logic [11:0] vcmd;
	logic [11:0] dac_ref;
	logic [11:0] bus_code;
	logic [11:0] cur_peak;
	logic [15:0] mod_factor;
	logic [IS_W-1:0] istat;
	logic [IS_W-1:0] imask;
	tpm_sys_t    sys_state;
	tpm_run_t    run_state;
	logic [31:0] cnt;
	logic        ov_now;
	logic        uv_now;

	// Bus decode
	wire wr_cmd   = wr && addr == REG_CMD;
	wire wr_istat = wr && addr == REG_ISTAT;
	wire ev_drive = wr_cmd && wdata[CMD_DRIVE];
	wire ev_stop  = wr_cmd && wdata[CMD_STOP];
	wire ev_reset = wr_cmd && wdata[CMD_RESET];

	// Comparator pin: three flops, a change counts once the last two agree
	logic [2:0] oc_sync;
	logic       oc_pin;
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			oc_sync <= 3'h0;
			oc_pin  <= 1'b0;
		end else begin
			oc_sync <= {oc_sync[1:0], overcurrent_comparator};
			if (oc_sync[1] == oc_sync[2])
				oc_pin <= oc_sync[2];
		end
	end

	// Bus voltage checks use the latest sample only
	wire ov_det = bus_valid && bus_voltage_channel > OV_CODE;
	wire uv_det = bus_valid && bus_voltage_channel < UV_CODE;

	// Current magnitude from whichever shunt arrangement is selected
	wire [11:0] mag_s = cur_mag(shunt_current_channel);
	wire [11:0] mag_u = cur_mag(u_current_channel);
	wire [11:0] mag_v = cur_mag(v_current_channel);
	wire [11:0] mag_w = cur_mag(w_current_channel);
	wire [11:0] mag_uv = (mag_u > mag_v) ? mag_u : mag_v;
	wire [11:0] mag_3 = (mag_uv > mag_w) ? mag_uv : mag_w;
	wire [11:0] mag = three_shunt ? mag_3 : mag_s;
	// Same reference serves both the trip level and the position threshold
	wire over_ref = current_valid && mag > dac_ref;
	wire in_pos = run_state == position_detect_running;
	wire pos_hit = in_pos && over_ref;
	wire oc_det = (over_ref && !in_pos) || oc_pin;
	wire fault = ov_det || uv_det || oc_det;

	// Sample latches
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			bus_code <= 12'h000;
			ov_now   <= 1'b0;
			uv_now   <= 1'b0;
		end else if (bus_valid) begin
			bus_code <= bus_voltage_channel;
			ov_now   <= ov_det;
			uv_now   <= uv_det;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			cur_peak <= 12'h000;
		else if (current_valid)
			cur_peak <= mag;
	end

	// Configuration and reference registers
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			modulation_select <= CFG_MOD_RST;
			three_shunt       <= 1'b0;
			ref_u   <= 16'h0000;
			ref_v   <= 16'h0000;
			ref_w   <= 16'h0000;
			vcmd    <= 12'h000;
			dac_ref <= DAC_RST;
			imask   <= '0;
		end else if (wr) begin
			if (addr == REG_CFG) begin
				modulation_select <= wdata[1:0];
				three_shunt       <= wdata[CFG_SHUNT];
			end
			if (addr == REG_REFU)
				ref_u <= wdata[15:0];
			if (addr == REG_REFV)
				ref_v <= wdata[15:0];
			if (addr == REG_REFW)
				ref_w <= wdata[15:0];
			if (addr == REG_VCMD)
				vcmd <= wdata[11:0];
			if (addr == REG_DAC)
				dac_ref <= wdata[11:0];
			if (addr == REG_IMASK)
				imask <= wdata[IS_W-1:0];
		end
	end

	// Sticky status; a new event wins over a write-one clear
	wire [IS_W-1:0] ev_set = {pos_hit, oc_det, uv_det, ov_det};
	wire [IS_W-1:0] ev_clr = wr_istat ? wdata[IS_W-1:0] : '0;
	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			istat <= '0;
		else
			istat <= (istat & ~ev_clr) | ev_set;
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			irq <= 1'b0;
		else
			irq <= |(((istat & ~ev_clr) | ev_set) & imask);
	end

	// Sequencer step conditions
	wire cnt_cal  = cnt >= 32'(OFFSET_CAL_CYC - 1);
	wire cnt_open = cnt >= 32'(OPEN_LOOP_CYC - 1);
	wire cnt_pos  = cnt >= 32'(POS_LIMIT_CYC - 1);
	wire pos_fail = in_pos && cnt_pos;
	wire err_ev = fault || pos_fail;

	// System and run states move only on events or on a finished step
	tpm_sys_t next_sys;
	tpm_run_t next_run;
	always_comb begin
		next_sys = sys_state;
		next_run = run_state;
		unique case (sys_state)
			SYS_STOPPED: begin
				if (err_ev) begin
					next_sys = SYS_ABNORMAL;
				end else if (ev_drive) begin
					next_sys = SYS_DRIVING;
					next_run = offset_cal_running;
				end
			end
			SYS_DRIVING: begin
				if (err_ev) begin
					next_sys = SYS_ABNORMAL;
					next_run = drive_end;
				end else if (ev_stop) begin
					next_run = drive_end;
				end else begin
					unique case (run_state)
						offset_cal_running:
							if (cnt_cal)
								next_run = offset_cal_done;
						offset_cal_done:
							next_run = position_detect_running;
						position_detect_running:
							if (pos_hit)
								next_run = position_detect_done;
						position_detect_done:
							next_run = open_loop_start;
						open_loop_start:
							if (cnt_open)
								next_run = closed_loop_drive;
						closed_loop_drive:
							next_run = closed_loop_drive;
						drive_brake:
							next_run = drive_brake; // No action, held
						drive_end:
							next_sys = SYS_STOPPED;
					endcase
				end
			end
			SYS_ABNORMAL: begin
				if (ev_reset && !fault) begin
					next_sys = SYS_STOPPED;
					next_run = drive_end;
				end
			end
		endcase
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			sys_state <= SYS_STOPPED;
			run_state <= drive_end;
		end else begin
			sys_state <= next_sys;
			run_state <= next_run;
		end
	end

	// Step timer restarts on every run state change
	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			cnt <= 32'h0;
		else if (next_run != run_state)
			cnt <= 32'h0;
		else
			cnt <= cnt + 32'h1;
	end

	// Modulation factor vcmd/bus in Q12, sequential so no wide divider
	logic [23:0] div_rem;
	logic [11:0] div_den;
	logic [23:0] div_quo;
	logic [4:0]  div_n;
	wire         div_busy = div_n != 5'h0;
	wire [24:0]  div_try = {div_rem, 1'b0};
	wire [24:0]  div_den_s = {1'b0, div_den, 12'h000};
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			div_rem    <= 24'h0;
			div_den    <= 12'h0;
			div_quo    <= 24'h0;
			div_n      <= 5'h0;
			mod_factor <= 16'h0;
		end else if (!div_busy && bus_valid) begin
			div_rem <= {12'h000, vcmd};
			div_den <= bus_voltage_channel;
			div_quo <= 24'h0;
			div_n   <= 5'd25;
		end else if (div_busy) begin
			div_n <= div_n - 5'h1;
			if (div_den == 12'h000) begin
				div_n      <= 5'h0;
				mod_factor <= 16'hffff; // Saturate on a dead bus
			end else if (div_n == 5'h1) begin
				mod_factor <= (|div_quo[23:16]) ? 16'hffff : div_quo[15:0];
			end else if (div_try >= div_den_s) begin
				div_rem <= 24'(div_try - div_den_s);
				div_quo <= {div_quo[22:0], 1'b1};
			end else begin
				div_rem <= div_try[23:0];
				div_quo <= {div_quo[22:0], 1'b0};
			end
		end
	end

	// Offset injection for the selected scheme
	wire signed [13:0] ru = 14'(signed'(ref_u));
	wire signed [13:0] rv = 14'(signed'(ref_v));
	wire signed [13:0] rw = 14'(signed'(ref_w));
	wire signed [13:0] r_max = max3(ru, rv, rw);
	wire signed [13:0] r_min = min3(ru, rv, rw);
	wire signed [13:0] half_bus = signed'({3'b000, bus_code[11:1]});
	wire signed [13:0] off_th = 14'((15'(r_max) + 15'(r_min)) >>> 1);
	wire signed [13:0] off_2p = r_max - half_bus;
	wire signed [13:0] vo = (modulation_select == two_phase_scheme) ? off_2p :
		(modulation_select == carrier_compare_scheme) ? 14'sh0 : off_th;
	wire signed [13:0] cu = ru - vo;
	wire signed [13:0] cv = rv - vo;
	wire signed [13:0] cw = rw - vo;

	// Triangle carrier spanning the signed code range, stepped by a divider enable
	logic [7:0]  div_cnt;
	logic        car_en;
	logic signed [13:0] carrier;
	logic        car_up;
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			div_cnt <= 8'h0;
			car_en  <= 1'b0;
		end else begin
			car_en  <= div_cnt == 8'(CAR_DIV - 1);
			div_cnt <= (div_cnt == 8'(CAR_DIV - 1)) ? 8'h0 : div_cnt + 8'h1;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			carrier <= -14'sd2048;
			car_up  <= 1'b1;
		end else if (car_en) begin
			if (car_up && carrier >= 14'sd2047)
				car_up <= 1'b0;
			else if (!car_up && carrier <= -14'sd2047)
				car_up <= 1'b1;
			carrier <= car_up ? ((carrier >= 14'sd2047) ? carrier - 14'sd1 : carrier + 14'sd1)
				: ((carrier <= -14'sd2047) ? carrier + 14'sd1 : carrier - 14'sd1);
		end
	end

	// Outputs on only in the switching sub-states and with a sound bus
	wire run_sw = sys_state == SYS_DRIVING && (in_pos ||
		run_state == open_loop_start || run_state == closed_loop_drive);
	wire shut = fault || ov_now || uv_now || sys_state == SYS_ABNORMAL;
	wire [2:0] hi = {cw > carrier, cv > carrier, cu > carrier};
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			pwm_out <= 6'h00;
			forced_output_shutoff <= 1'b0;
		end else begin
			forced_output_shutoff <= shut;
			if (shut || !run_sw)
				pwm_out <= 6'h00;
			else
				pwm_out <= {~hi[2], hi[2], ~hi[1], hi[1], ~hi[0], hi[0]};
		end
	end

	// Read mux; unmapped addresses read zero
	logic [31:0] rd_mux;
	always_comb begin
		rd_mux = 32'h0;
		unique case (addr)
			REG_CFG:   rd_mux = {29'h0, three_shunt, modulation_select};
			REG_REFU:  rd_mux = {16'h0, ref_u};
			REG_REFV:  rd_mux = {16'h0, ref_v};
			REG_REFW:  rd_mux = {16'h0, ref_w};
			REG_VCMD:  rd_mux = {20'h0, vcmd};
			REG_DAC:   rd_mux = {20'h0, dac_ref};
			REG_STATE: rd_mux = {4'h0, cur_peak, 5'h0, sys_state, run_state};
			REG_BUS:   rd_mux = {20'h0, bus_code};
			REG_MODF:  rd_mux = {16'h0, mod_factor};
			REG_ISTAT: rd_mux = {28'h0, istat};
			REG_IMASK: rd_mux = {28'h0, imask};
			default:   rd_mux = 32'h0;
		endcase
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			rdata <= 32'h0;
		else
			rdata <= rd ? rd_mux : 32'h0;
	end
endmodule
`default_nettype wire

// *** dv/tpm_inverter_model.sv ***
// Inverter power stage model: sampled bus voltage, link current and trip pin
`timescale 1ns/100ps
`default_nettype none
module tpm_inverter_model (
	input  wire logic               clk,
	input  wire logic               rst,
	input  wire logic signed [31:0] bus_mv,
	input  wire logic signed [31:0] phase_ma,
	input  wire logic               trip,
	output logic             [11:0] bus_voltage_channel,
	output logic                    bus_valid,
	output logic             [11:0] cur_code,
	output logic                    current_valid,
	output logic                    overcurrent_comparator
);
	logic [2:0]  tick;
	logic [11:0] bus_lin;
	logic [11:0] cur_lin;

	// Linear scaling of the sensed quantities
	assign bus_lin = 12'(bus_mv * 4095 / 111000);
	assign cur_lin = 12'((phase_ma + 5000) * 4095 / 10000);

	// Codes are only good beside their strobe, inverted otherwise to catch misuse
	assign bus_valid              = (tick == 3'h7);
	assign current_valid          = (tick == 3'h3);
	assign bus_voltage_channel    = bus_valid ? bus_lin : ~bus_lin;
	assign cur_code               = current_valid ? cur_lin : ~cur_lin;
	assign overcurrent_comparator = trip;

	// Conversion pacing
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			tick <= 3'h0;
		end else begin
			tick <= tick + 3'h1;
		end
	end
endmodule
`default_nettype wire

// *** dv/tpm_modulator_chk.sv ***
// Port checker for the three-phase PWM modulator
`timescale 1ns/100ps
`default_nettype none
module tpm_modulator_chk
	import tpm_pkg::*;
#(
	parameter int OFFSET_CAL_CYC = 20,
	parameter int OPEN_LOOP_CYC  = 20,
	parameter int POS_LIMIT_CYC  = 50
) (
	input wire logic        clk,
	input wire logic        rst,
	input wire logic [7:0]  addr,
	input wire logic [31:0] wdata,
	input wire logic        wr,
	input wire logic        rd,
	input wire logic [31:0] rdata,
	input wire logic [11:0] bus_voltage_channel,
	input wire logic        bus_valid,
	input wire logic [11:0] shunt_current_channel,
	input wire logic [11:0] u_current_channel,
	input wire logic [11:0] v_current_channel,
	input wire logic [11:0] w_current_channel,
	input wire logic        current_valid,
	input wire logic        overcurrent_comparator,
	input wire logic [5:0]  pwm_out,
	input wire logic        forced_output_shutoff,
	input wire logic        irq
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	// Bus samples outside the safe band
	sequence s_ov;
		bus_valid && (bus_voltage_channel > OV_CODE);
	endsequence
	sequence s_uv;
		bus_valid && (bus_voltage_channel < UV_CODE);
	endsequence
	// Flag first, bridge quiet one cycle later
	sequence s_shut_quiet;
		forced_output_shutoff ##1 (pwm_out == 6'h00);
	endsequence

	chk_ov_shuts_bridge: assert property (s_ov |=> s_shut_quiet)
		else $error("overvoltage sample left outputs on");
	chk_uv_shuts_bridge: assert property (s_uv |=> s_shut_quiet)
		else $error("undervoltage sample left outputs on");
	chk_shut_holds_off: assert property (forced_output_shutoff && $past(forced_output_shutoff)
		|-> pwm_out == 6'h00)
		else $error("outputs active during shutoff");
	chk_legs_complement: assert property (pwm_out != 6'h00 |->
		&{pwm_out[0] ^ pwm_out[1], pwm_out[2] ^ pwm_out[3], pwm_out[4] ^ pwm_out[5]})
		else $error("leg pair not complementary");
	chk_trip_pin_shuts: assert property (overcurrent_comparator [*3]
		|-> ##[1:6] forced_output_shutoff)
		else $error("trip pin did not shut outputs");
	// Only a register write may lift a shutoff; the write lands a cycle or two late
	chk_latch_until_cmd: assert property (forced_output_shutoff && !wr && !$past(wr)
		&& !$past(wr, 2) |=> forced_output_shutoff)
		else $error("shutoff released without command");
	chk_read_one_shot: assert property (rdata != 32'h0 |-> $past(rd))
		else $error("read data outside read slot");
	chk_irq_drop_write: assert property ($fell(irq) |-> $past(wr))
		else $error("interrupt fell without a write");
endmodule
`default_nettype wire

bind tpm_modulator tpm_modulator_chk #(.OFFSET_CAL_CYC(OFFSET_CAL_CYC),
	.OPEN_LOOP_CYC(OPEN_LOOP_CYC), .POS_LIMIT_CYC(POS_LIMIT_CYC)) u_chk (
	.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
	.bus_voltage_channel(bus_voltage_channel), .bus_valid(bus_valid),
	.shunt_current_channel(shunt_current_channel), .u_current_channel(u_current_channel),
	.v_current_channel(v_current_channel), .w_current_channel(w_current_channel),
	.current_valid(current_valid), .overcurrent_comparator(overcurrent_comparator),
	.pwm_out(pwm_out), .forced_output_shutoff(forced_output_shutoff), .irq(irq));

// *** dv/three_phase_pwm_modulator_tb_top.sv ***
// Register-level bench for the three-phase PWM modulator
`timescale 1ns/100ps
`default_nettype none
module three_phase_pwm_modulator_tb_top import tpm_pkg::*;;
	logic               clk      = 1'b0;
	logic               rst      = 1'b1;
	logic [7:0]         addr     = 8'h00;
	logic [31:0]        wdata    = 32'h0;
	logic               wr       = 1'b0;
	logic               rd       = 1'b0;
	logic               trip     = 1'b0;
	logic signed [31:0] bus_mv   = 24000;
	logic signed [31:0] phase_ma = 0;
	logic [31:0]        rdata;
	logic [11:0]        bus_code;
	logic [11:0]        cur_code;
	logic               bus_valid;
	logic               current_valid;
	logic               trip_pin;
	logic [5:0]         pwm_out;
	logic               shut;
	logic               irq;
	logic [31:0]        word;
	int                 hi [3];
	int                 n_errors = 0;
	int                 checked  = 0;

	// 50 MHz clock
	always #10 clk = ~clk;

	tpm_modulator #(.OFFSET_CAL_CYC(20), .OPEN_LOOP_CYC(20), .POS_LIMIT_CYC(50)) u_dut (
		.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
		.bus_voltage_channel(bus_code), .bus_valid(bus_valid),
		.shunt_current_channel(cur_code), .u_current_channel(cur_code),
		.v_current_channel(cur_code), .w_current_channel(cur_code),
		.current_valid(current_valid), .overcurrent_comparator(trip_pin),
		.pwm_out(pwm_out), .forced_output_shutoff(shut), .irq(irq));

	tpm_inverter_model u_stage (
		.clk(clk), .rst(rst), .bus_mv(bus_mv), .phase_ma(phase_ma), .trip(trip),
		.bus_voltage_channel(bus_code), .bus_valid(bus_valid), .cur_code(cur_code),
		.current_valid(current_valid), .overcurrent_comparator(trip_pin));

	// Compare and count
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			n_errors++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// One-cycle write strobe
	task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		addr  <= a;
		wdata <= d;
		wr    <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask

	// Read data stand only in the cycle after the strobe
	task automatic rd_reg(input logic [7:0] a);
		@(posedge clk);
		addr <= a;
		rd   <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		word = rdata;
	endtask

	task automatic idle(input int n);
		repeat (n) @(posedge clk);
	endtask

	// Bounded poll of the run step
	task automatic wait_run(input logic [7:0] run);
		int i;
		i = 0;
		rd_reg(REG_STATE);
		while (word[7:0] !== run && i < 200) begin
			rd_reg(REG_STATE);
			i++;
		end
		check("run step", 32'(word[7:0]), 32'(run));
	endtask

	// High-side on-time per phase over a window
	task automatic sample_pwm(input int n);
		hi = '{0, 0, 0};
		repeat (n) begin
			@(posedge clk);
			#1;
			for (int k = 0; k < 3; k++) hi[k] += int'(pwm_out[2 * k]);
		end
	endtask

	task automatic tally_and_finish;
		$display("comparisons %0d mismatches %0d", checked, n_errors);
		if (n_errors == 0 && checked > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	// Watchdog well beyond the planned run length
	initial begin
		repeat (60000) @(posedge clk);
		n_errors++;
		tally_and_finish();
	end

	// Test sequence
	initial begin
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		rd_reg(REG_CFG);
		check("cfg reset", word, 32'h1);
		rd_reg(REG_DAC);
		check("dac reset", word, 32'hfff);
		rd_reg(REG_STATE);
		check("sys state", 32'(word[10:8]), 32'h1);
		rd_reg(8'h30);
		check("unmapped", word, 32'h0);
		$display("reset values done");

		idle(16);
		rd_reg(REG_BUS);
		check("bus code", word, 32'(24000 * 4095 / 111000));
		wr_reg(REG_VCMD, 32'h100);
		idle(80);
		rd_reg(REG_MODF);
		check("mod factor", word, 32'(256 * 4096 / (24000 * 4095 / 111000)));
		$display("scaling done");

		// Drive: threshold dropped over one current sample so detection ends without a trip
		phase_ma <= 1000;
		wr_reg(REG_CMD, 32'h1);
		rd_reg(REG_STATE);
		check("sys state", 32'(word[10:8]), 32'h2);
		check("run step", 32'(word[7:0]), 32'h1);
		wait_run(8'h04);
		check("current mag", 32'(word[27:16]), 32'(6000 * 4095 / 10000 - 2048));
		@(posedge clk iff current_valid);
		wr_reg(REG_DAC, 32'h100);
		idle(6);
		wr_reg(REG_DAC, 32'hfff);
		wait_run(8'h20);
		wr_reg(REG_REFU, 32'd4200);
		wr_reg(REG_REFV, 32'd4200);
		wr_reg(REG_REFW, 32'd0);
		for (int s = 0; s < 3; s++) begin
			wr_reg(REG_CFG, 32'(s) | (32'(s == 1) << CFG_SHUNT));
			idle(4);
			sample_pwm(8200);
			check("u always on", 32'(hi[0] == 8200), 32'(s != 2));
			check("v as u", 32'(hi[1]), 32'(hi[0]));
			check("w always off", 32'(hi[2] == 0), 32'(s != 0));
			check("w switching", 32'(hi[2] > 0 && hi[2] < 8200), 32'(s == 0));
			rd_reg(REG_STATE);
			check("current mag", 32'(word[27:16]), 32'(6000 * 4095 / 10000 - 2048));
		end
		rd_reg(REG_STATE);
		check("run step", 32'(word[7:0]), 32'h20);
		wr_reg(REG_CMD, 32'h2);
		idle(4);
		rd_reg(REG_STATE);
		check("sys state", 32'(word[10:8]), 32'h1);
		check("bridge idle", 32'(pwm_out), 32'h0);
		$display("drive and modulation done");

		// Faults: overvoltage, undervoltage, trip pin; only overvoltage unmasked
		wr_reg(REG_IMASK, 32'(1 << IS_OV));
		for (int f = 0; f < 3; f++) begin
			bus_mv <= (f == 0) ? 30000 : (f == 1) ? 10000 : 24000;
			trip   <= (f == 2);
			idle(20);
			rd_reg(REG_ISTAT);
			check("fault flag", 32'(word[f]), 32'h1);
			check("irq level", 32'(irq), 32'(f == 0));
			check("shutoff", 32'(shut), 32'h1);
			wr_reg(REG_CMD, 32'h1);
			rd_reg(REG_STATE);
			check("sys state", 32'(word[10:8]), 32'h4);
			bus_mv <= 24000;
			trip   <= 1'b0;
			idle(20);
			wr_reg(REG_ISTAT, 32'hf);
			wr_reg(REG_CMD, 32'h4);
			idle(2);
			check("irq cleared", 32'(irq), 32'h0);
			rd_reg(REG_STATE);
			check("sys state", 32'(word[10:8]), 32'h1);
			check("shutoff", 32'(shut), 32'h0);
		end
		$display("fault handling done");

		// Detection never reaches its threshold
		phase_ma <= 0;
		wr_reg(REG_CMD, 32'h1);
		idle(100);
		rd_reg(REG_STATE);
		check("sys state", 32'(word[10:8]), 32'h4);
		$display("detection timeout done");
		tally_and_finish();
	end
endmodule
`default_nettype wire
